/* logic/epso_edge.v */
`timescale 1ns/1ns
// Two-flop synchroniser for a pin, with a third stage for edge detection.
module epso_edge (
	input  wire clk,
	input  wire rst,
	input  wire pin,
	output wire level,
	output wire rise,
	output wire fall
);
	reg meta;
	reg stable;
	reg prev;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meta   <= 1'b1;
			stable <= 1'b1;
			prev   <= 1'b1;
		end else begin
			meta   <= pin;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign level = stable;
	assign rise  = stable & ~prev;
	assign fall  = ~stable & prev;
endmodule // epso_edge

/* logic/epso_map.vh */
`ifndef EPSO_MAP_VH
`define EPSO_MAP_VH

// -----------------------------------------------------------------------------
// Timing, all figures in nanoseconds
// -----------------------------------------------------------------------------
`define EPSO_CLK_PERIOD_NS   10
`define EPSO_MEAS_MIN_NS     90000
`define EPSO_MEAS_MAX_NS     95000
`define EPSO_MTO_MIN_NS      135000
`define EPSO_MTO_MAX_NS      145000
`define EPSO_SPI_IDLE_NS     10000
`define EPSO_BISS_TO_MIN_NS  15000
`define EPSO_BISS_TO_MAX_NS  20000

// -----------------------------------------------------------------------------
// Angle word
// -----------------------------------------------------------------------------
`define EPSO_ANGLE_BITS      22
`define EPSO_ANGLE_ONES      22'h3fffff

// -----------------------------------------------------------------------------
// Byte-framed serial word
// -----------------------------------------------------------------------------
`define EPSO_SPI_BITS        48
`define EPSO_SPI_PAD_BITS    15
`define EPSO_SPI_BODY_BITS   26
`define EPSO_CRC7_POLY       7'h5b
`define EPSO_CRC7_INIT       7'h00

// -----------------------------------------------------------------------------
// Clocked-line single-cycle data
// -----------------------------------------------------------------------------
`define EPSO_BISS_ACK_CYC    6'h0c
`define EPSO_BISS_START_CYC  6'h0d
`define EPSO_BISS_CDS_CYC    6'h0e
`define EPSO_BISS_LAST_CYC   6'h2c
`define EPSO_BISS_SCD_BITS   30
`define EPSO_BISS_DATA_BITS  24
`define EPSO_CRC6_POLY       7'h43
`define EPSO_CRC6_INIT       6'h00

`endif

/* logic/epso_top.v */
`timescale 1ns/1ns
`include "epso_map.vh"

// Summary of operation
// - Measurement result ready 90 to 95 us.
// - Self-trigger after 135 to 145 us quiet.
// - Frame start triggers measurement when idle.
// - Frame during measurement does not restart it.
// - Frames carry latest completed measurement.
// - Clock idle 10 us resets SPI framing.
// - Master clocks, device answers; chain input zero.
// - BiSS returns previous frame's measurement.
// - Single-cycle data is 24 data plus CRC.
// - Twelve clock cycles before start bit.
// - Data: left-aligned angle, error, warning bits.
// - Error bit one when valid; warning always one.
// - Clock idles high; output changes on rise.
// - 48-bit frame: pad, flags, angle, stale, CRC.
// - CRC7 poly 0x5B, zero init, MSB first.
// - Synced flag marks frame trigger; stale once sent.
module epso_top #(
	parameter RES_BITS = 22,
	parameter MEAS_CYC = ((`EPSO_MEAS_MIN_NS + `EPSO_MEAS_MAX_NS) / 2) / `EPSO_CLK_PERIOD_NS,
	parameter MTO_CYC  = ((`EPSO_MTO_MIN_NS + `EPSO_MTO_MAX_NS) / 2) / `EPSO_CLK_PERIOD_NS
) (
	input  wire        clk,
	input  wire        rst,
	input  wire        biss_mode,
	input  wire        serial_clock,
	input  wire        chain_input,
	input  wire [21:0] angle_value,
	input  wire        angle_ok,
	input  wire        zero_point_factory_flag,
	output reg         data_out,
	output wire        meas_start,
	output reg         meas_busy,
	output reg         frame_active
);
	// -------------------------------------------------------------------------
	// Constants
	// -------------------------------------------------------------------------
	localparam integer SPI_IDLE_NUM = `EPSO_SPI_IDLE_NS / `EPSO_CLK_PERIOD_NS;
	localparam integer BISS_TO_NUM  = ((`EPSO_BISS_TO_MIN_NS + `EPSO_BISS_TO_MAX_NS) / 2) / `EPSO_CLK_PERIOD_NS;
	localparam [10:0]  SPI_IDLE_CYC = SPI_IDLE_NUM[10:0];
	localparam [10:0]  BISS_TO_CYC  = BISS_TO_NUM[10:0];
	localparam [21:0] RES_MASK     = `EPSO_ANGLE_ONES >> (`EPSO_ANGLE_BITS - RES_BITS);
	localparam        BISS_SHIFT   = `EPSO_ANGLE_BITS - RES_BITS;

	function [6:0] crc7;
		input [25:0] body;
		integer i;
		reg fb;
		begin
			crc7 = `EPSO_CRC7_INIT;
			for (i = 25; i >= 0; i = i - 1) begin
				fb   = body[i] ^ crc7[6];
				crc7 = {crc7[5:0], 1'b0} ^ (fb ? `EPSO_CRC7_POLY : 7'h00);
			end
		end
	endfunction

	function [5:0] crc6;
		input [23:0] body;
		integer i;
		reg fb;
		reg [6:0] poly;
		begin
			poly = `EPSO_CRC6_POLY;
			crc6 = `EPSO_CRC6_INIT;
			for (i = 23; i >= 0; i = i - 1) begin
				fb   = body[i] ^ crc6[5];
				crc6 = {crc6[4:0], 1'b0} ^ (fb ? poly[5:0] : 6'h00);
			end
		end
	endfunction

	// -------------------------------------------------------------------------
	// Pin synchronisers
	// -------------------------------------------------------------------------
	wire clk_rise;
	wire clk_fall;
	wire chain_sync;

	epso_edge u_clk_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (serial_clock),
		.level (),
		.rise  (clk_rise),
		.fall  (clk_fall)
	);

	// Only its level is used; the edge outputs are left open.
	epso_edge u_chain_sync (
		.clk   (clk),
		.rst   (rst),
		.pin   (chain_input),
		.level (chain_sync),
		.rise  (),
		.fall  ()
	);

	// -------------------------------------------------------------------------
	// Measurement scheduler
	// -------------------------------------------------------------------------
	reg  [31:0] meas_cnt;
	reg  [31:0] mto_cnt;
	reg  [21:0] res_angle;
	reg         res_valid;
	reg         res_synced;
	reg         res_zero_point;
	reg         res_stale;
	reg         pend_synced;
	wire        frame_start = clk_fall & ~frame_active;
	wire        host_trig   = frame_start & ~meas_busy;
	wire        mto_trig    = (mto_cnt >= MTO_CYC - 1) & ~meas_busy & ~host_trig;
	wire        meas_done   = meas_busy & (meas_cnt == MEAS_CYC - 1);

	assign meas_start = host_trig | mto_trig;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			meas_busy   <= 1'b0;
			meas_cnt    <= 32'h0;
			mto_cnt     <= 32'h0;
			pend_synced <= 1'b0;
			res_angle   <= 22'h0;
			res_valid   <= 1'b0;
			res_synced  <= 1'b0;
			res_zero_point <= 1'b0;
			res_stale   <= 1'b0;
		end else begin
			if (meas_start) begin
				meas_busy   <= 1'b1;
				meas_cnt    <= 32'h0;
				mto_cnt     <= 32'h0;
				pend_synced <= host_trig;
			end else begin
				if (meas_busy) begin
					meas_cnt <= meas_cnt + 32'h1;
				end
				if (mto_cnt < MTO_CYC - 1) begin
					mto_cnt <= mto_cnt + 32'h1;
				end
			end
			if (meas_done) begin
				meas_busy  <= 1'b0;
				res_angle  <= angle_value & RES_MASK;
				res_valid  <= angle_ok;
				res_zero_point <= zero_point_factory_flag;
				res_synced <= pend_synced;
			end
			// A fresh result outranks a frame marking the old one as sent.
			if (meas_done) begin
				res_stale <= 1'b0;
			end else if (frame_start) begin
				res_stale <= 1'b1;
			end
		end
	end

	// -------------------------------------------------------------------------
	// Frame words, built from the latest completed result
	// -------------------------------------------------------------------------
	wire [25:0] spi_body   = {res_zero_point, res_valid, res_synced, res_angle, res_stale};
	wire [47:0] spi_word   = {{`EPSO_SPI_PAD_BITS{1'b0}}, spi_body, crc7(spi_body)};
	wire [21:0] biss_angle = res_angle << BISS_SHIFT;
	wire [23:0] biss_data  = {biss_angle, res_valid, 1'b1};
	wire [29:0] biss_word  = {biss_data, ~crc6(biss_data)};

	// -------------------------------------------------------------------------
	// Serial slave
	// -------------------------------------------------------------------------
	reg  [47:0] shifter;
	reg  [5:0]  rise_cnt;
	reg  [10:0] idle_cnt;
	wire [5:0]  next_rise_cnt = (rise_cnt == `EPSO_BISS_LAST_CYC) ? rise_cnt : rise_cnt + 6'h1;
	wire [10:0] idle_limit    = biss_mode ? BISS_TO_CYC : SPI_IDLE_CYC;
	wire        idle_level    = biss_mode;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			frame_active <= 1'b0;
			shifter      <= 48'h0;
			rise_cnt     <= 6'h0;
			idle_cnt     <= 11'h0;
			data_out     <= 1'b0;
		end else begin
			if (clk_rise | clk_fall) begin
				idle_cnt <= 11'h0;
			end else if (idle_cnt < idle_limit) begin
				idle_cnt <= idle_cnt + 11'h1;
			end
			if (frame_start) begin
				// The first bit of either frame is a constant, already on the line.
				frame_active <= 1'b1;
				rise_cnt     <= 6'h0;
				if (biss_mode) begin
					shifter <= {biss_word, 18'h0};
				end else begin
					shifter <= {spi_word[46:0], 1'b0};
				end
			end else if (frame_active & clk_rise) begin
				rise_cnt <= next_rise_cnt;
				if (!biss_mode) begin
					data_out <= shifter[47];
					shifter  <= {shifter[46:0], 1'b0};
				end else if (next_rise_cnt <= `EPSO_BISS_ACK_CYC) begin
					data_out <= 1'b0;
				end else if (next_rise_cnt == `EPSO_BISS_START_CYC) begin
					data_out <= 1'b1;
				end else if (next_rise_cnt == `EPSO_BISS_CDS_CYC) begin
					data_out <= 1'b0;
				end else if (rise_cnt < `EPSO_BISS_LAST_CYC) begin
					data_out <= shifter[47];
					shifter  <= {shifter[46:0], 1'b0};
				end else begin
					// Timeout low; the chain input is held at zero outside.
					data_out <= chain_sync;
				end
			end else if (frame_active & (idle_cnt >= idle_limit)) begin
				frame_active <= 1'b0;
				data_out     <= idle_level;
			end else if (!frame_active) begin
				data_out <= idle_level;
			end
		end
	end
endmodule // epso_top

/* tb/epso_asserts.sv */
`timescale 1ns/1ns
module epso_asserts #(
	parameter MEAS_CYC = 9250,
	parameter MTO_CYC  = 14000
) (
	input wire clk,
	input wire rst,
	input wire biss_mode,
	input wire data_out,
	input wire meas_start,
	input wire meas_busy,
	input wire frame_active
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	int unsigned since;
	// Cycles since the last trigger; both measurement time and time-out hang on it.
	always @(posedge clk or posedge rst) begin
		if (rst)
			since <= 0;
		else if (meas_start)
			since <= 0;
		else
			since <= since + 1;
	end
	a_busy_after_start: assert property (meas_start |=> meas_busy) else $error("busy did not follow start");
	a_meas_length: assert property ($fell(meas_busy) |-> since == MEAS_CYC) else $error("bad measure time");
	a_timeout_bound: assert property (since < MTO_CYC) else $error("no time-out trigger");
	a_no_restart: assert property (meas_busy |-> !meas_start) else $error("measurement restarted");
	a_start_pulse: assert property (meas_start |=> !meas_start) else $error("start pulse too long");
	a_frame_trigger: assert property ($rose(frame_active) |-> $past(meas_start) || $past(meas_busy))
		else $error("frame start did not trigger");
	a_spi_idle_low: assert property (!biss_mode && !$past(biss_mode) && !frame_active |-> !data_out)
		else $error("serial idle not low");
	a_biss_idle_high: assert property (biss_mode && $past(biss_mode) && !$past(rst) && !frame_active |-> data_out)
		else $error("line idle not high");
	cover property ($rose(frame_active) && $past(meas_busy));
	cover property ($fell(meas_busy));
	cover property (biss_mode && $rose(frame_active));
endmodule // epso_asserts

bind epso_top epso_asserts #(.MEAS_CYC(MEAS_CYC), .MTO_CYC(MTO_CYC)) u_chk (.clk(clk), .rst(rst),
	.biss_mode(biss_mode), .data_out(data_out), .meas_start(meas_start), .meas_busy(meas_busy),
	.frame_active(frame_active));

/* tb/epso_host.sv */
`timescale 1ns/1ns
// Serial master: clock idles high and stands still between frames.
module epso_host (
	input  wire clk,
	output reg  sclk,
	input  wire sdo
);
	initial sclk <= 1'b1;
	// Each half period is eight system clocks, so the line only moves on system edges.
	task automatic xfer(input int n, output logic [47:0] got);
		got = 48'h0;
		repeat (n) begin
			sclk <= 1'b0;
			got = {got[46:0], sdo};
			repeat (8) @(posedge clk);
			sclk <= 1'b1;
			repeat (8) @(posedge clk);
		end
	endtask
endmodule // epso_host

/* tb/tb.sv */
`timescale 1ns/1ns
`include "epso_map.vh"
module tb;
	localparam MEAS = 2500;
	localparam MTO  = 4000;
	reg          clk = 1'b0;
	reg          rst = 1'b1;
	reg          biss_mode = 1'b0;
	reg  [21:0]  angle = 22'h000000;
	reg          ok = 1'b1;
	reg          zero_flag = 1'b1;
	wire         sclk;
	wire         sdo;
	logic [47:0] got;
	int          mismatches = 0;
	int          check_count = 0;
	always #5 clk = ~clk;
	epso_host u_host (.clk(clk), .sclk(sclk), .sdo(sdo));
	epso_top #(.RES_BITS(18), .MEAS_CYC(MEAS), .MTO_CYC(MTO)) DUT (.clk(clk), .rst(rst), .biss_mode(biss_mode),
		.serial_clock(sclk), .chain_input(1'b0), .angle_value(angle), .angle_ok(ok),
		.zero_point_factory_flag(zero_flag), .data_out(sdo), .meas_start(), .meas_busy(), .frame_active());
	function automatic [6:0] crc(input [25:0] d, input int n, input [6:0] p, input int w);
		crc = 7'h00;
		for (int i = n - 1; i >= 0; i--)
			crc = ((crc << 1) ^ ((crc[w-1] ^ d[i]) ? p : 7'h00)) & ((7'h01 << w) - 7'h01);
	endfunction
	function automatic [47:0] spi_exp(input z, input [21:0] a, input s, input st);
		logic [25:0] b;
		b = {z, 1'b1, s, 4'h0, a[17:0], st};
		spi_exp = {15'h0000, b, crc(b, 26, `EPSO_CRC7_POLY, 7)};
	endfunction
	function automatic [47:0] biss_exp(input [21:0] a, input v);
		logic [25:0] d;
		logic [6:0]  c;
		d = {2'h0, a[17:0], 4'h0, v, 1'b1};
		c = crc(d, 24, `EPSO_CRC6_POLY, 6);
		biss_exp = {3'h1, 12'h000, 2'h2, d[23:0], ~c[5:0], 1'b0};
	endfunction
	task automatic check(input logic [47:0] g, input logic [47:0] e);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic gap(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic frame(input int n);
		@(posedge clk);
		u_host.xfer(n, got);
		@(posedge clk);
	endtask
	// Second frame lands inside the measurement that the first one started.
	task automatic spi_sequence;
		angle <= 22'h0a5a5c;
		gap(MTO + MEAS + 20);
		frame(48);
		check(got, spi_exp(1'b1, 22'h0a5a5c, 1'b0, 1'b0));
		angle <= 22'h13c3e1;
		zero_flag <= 1'b0;
		gap(1100);
		frame(48);
		check(got, spi_exp(1'b1, 22'h0a5a5c, 1'b0, 1'b1));
		angle <= 22'h2f0f1b;
		gap(1100);
		frame(48);
		check(got, spi_exp(1'b0, 22'h13c3e1, 1'b1, 1'b0));
	endtask
	task automatic biss_sequence;
		gap(1100);
		biss_mode <= 1'b1;
		gap(1800);
		frame(46);
		check(got, biss_exp(22'h2f0f1b, 1'b1));
		angle <= 22'h1234ab;
		ok <= 1'b0;
		gap(2000);
		frame(46);
		check(got, biss_exp(22'h1234ab, 1'b0));
	endtask
	task automatic print_verdict;
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		gap(4);
		rst <= 1'b0;
		spi_sequence;
		biss_sequence;
		print_verdict;
	end
	// The sequence needs about 17000 cycles; more than twice that means a hang.
	initial begin
		#400000;
		mismatches++;
		print_verdict;
	end
endmodule // tb
